// ---- vqc_pkg.sv ----
package vqc_pkg;
  localparam int          NUM_LINES   = 32;
  localparam int          NUM_SRC     = 33;
  localparam int          NUM_LEVELS  = 16;
  localparam int          ADDR_W      = 12;
  localparam logic [3:0]  LOWEST_LVL  = 4'hF;
  localparam logic [15:0] SWMASK_RST  = 16'hFFFF;
  localparam logic [5:0]  CHAIN_IDX   = 6'h20;

  localparam logic [11:0] RAW_OFS     = 12'h000;
  localparam logic [11:0] IRQST_OFS   = 12'h004;
  localparam logic [11:0] FIQST_OFS   = 12'h008;
  localparam logic [11:0] ENSET_OFS   = 12'h00C;
  localparam logic [11:0] ENCLR_OFS   = 12'h010;
  localparam logic [11:0] SELECT_OFS  = 12'h014;
  localparam logic [11:0] SWSET_OFS   = 12'h018;
  localparam logic [11:0] SWCLR_OFS   = 12'h01C;
  localparam logic [11:0] SAMP_OFS    = 12'h020;
  localparam logic [11:0] SAMPCLR_OFS = 12'h024;
  localparam logic [11:0] SWMASK_OFS  = 12'h028;
  localparam logic [11:0] SVC_OFS     = 12'h030;
  localparam logic [3:0]  ROUTINE_PG  = 4'h1;
  localparam logic [3:0]  LEVEL_PG    = 4'h2;

  typedef struct packed {
    logic       valid;
    logic [5:0] idx;
    logic [3:0] lvl;
  } vqc_win_t;

  typedef struct packed {
    logic [31:0]      s1Req;
    logic [31:0]      s2Req;
    logic [1:0]       s1Ch;
    logic [1:0]       s2Ch;
    logic [31:0]      enable;
    logic [31:0]      select;
    logic [31:0]      swReq;
    logic [31:0]      sampled;
    logic [15:0]      swMask;
    logic [15:0]      inService;
    logic [32:0][3:0] level;
    logic [31:0]      serviceAddr;
    logic [5:0]       winIdxQ;
    logic             winValidQ;
    logic [31:0]      rdData;
    logic             rdMem;
  } vqc_state_t;
endpackage : vqc_pkg

// ---- vqc_mem_if.sv ----
interface vqc_mem_if;
  logic        wrEn;
  logic [4:0]  wrIdx;
  logic [31:0] wrData;
  logic [4:0]  rdIdxA;
  logic [31:0] rdDataA;
  logic [4:0]  rdIdxB;
  logic [31:0] rdDataB;

  modport ctrl (output wrEn, wrIdx, wrData, rdIdxA, rdIdxB,
                input  rdDataA, rdDataB);
  modport mem  (input  wrEn, wrIdx, wrData, rdIdxA, rdIdxB,
                output rdDataA, rdDataB);
endinterface : vqc_mem_if

// ---- vqc_addr_mem.sv ----
module vqc_addr_mem #(
  parameter int DEPTH = 32
) (
  input  wire logic clk,
  input  wire logic rst_b,
  vqc_mem_if.mem    port
);
  import vqc_pkg::*;

  typedef struct packed {
    logic [DEPTH-1:0][31:0] word;
    logic [31:0]            rdA;
    logic [31:0]            rdB;
  } vqc_mem_state_t;

  vqc_mem_state_t st_ff;
  vqc_mem_state_t nxt_st;

  if (DEPTH != 32) begin : g_depth_chk
    $error("vqc_addr_mem: depth must match 5-bit index");
  end

  // Writes land a cycle before reads see them; port A indexes the same slot as the write
  always_comb begin
    nxt_st = st_ff;
    if (port.wrEn) begin
      nxt_st.word[port.wrIdx] = port.wrData;
    end
    nxt_st.rdA = st_ff.word[port.rdIdxA];
    nxt_st.rdB = st_ff.word[port.rdIdxB];
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign port.rdDataA = st_ff.rdA;
  assign port.rdDataB = st_ff.rdB;
endmodule : vqc_addr_mem

// ---- vqc_core.sv ----
// Notes on behaviour
// - Thirty-two vectored lines, IRQ only
// - FIQ first, then lines 0-31, chain last
// - Sixteen-level priority per each of 33 sources
// - Equal levels: lower index wins, chain loses
// - Service address read returns winner, arms mask
// - Service address write releases mask
// - Mask gates IRQ output, win flags and service address, not status
// - Software request bits ORed before enables
// - Disabled lines suppressed; select steers IRQ/FIQ
// - FIQ output merges local and chained FIQ
// - Win flag: active, unmasked, highest priority
// - Winner's routine address selected for output
// - Request outputs reach pins combinationally
// - IRQ and FIQ may assert together
// - Sticky sampled status, cleared by write
// - Chain inputs optionally registered
// - Acknowledge forwarded to chain when chain wins
// - Vanished source returns address, arms nothing
// - Reset priority level is 15
// - Port acknowledge arms mask like read
// - Idle service address keeps last winner
//
// Our own choices: strobed register access and the address map.
module vqc_core (
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  input  wire logic [vqc_pkg::ADDR_W-1:0] addr,
  input  wire logic [31:0]             wdata,
  input  wire logic                    wrStb,
  input  wire logic                    rdStb,
  output logic [31:0]                  rdata,
  input  wire logic [31:0]             hwReq,
  input  wire logic                    chain_irq_in_n,
  input  wire logic                    chain_fiq_in_n,
  input  wire logic [31:0]             chainAddrIn,
  input  wire logic                    chain_irq_register_sel,
  input  wire logic                    chain_fiq_register_sel,
  input  wire logic                    port_ack_in,
  output logic                         chain_ack_out,
  output logic                         irq_out_n,
  output logic                         fiq_out_n,
  output logic [31:0]                  slice_win_flag,
  output logic [31:0]                  slice_routine_addr
);
  import vqc_pkg::*;

  vqc_state_t  st_ff;
  vqc_state_t  nxt_st;
  vqc_mem_if   memBus ();

  logic [31:0] raw_request_status;
  logic [31:0] irq_routed_vector;
  logic [31:0] fiq_routed_vector;
  logic [31:0] irqVecSync;
  logic        chainIrq;
  logic        chainFiq;
  logic [15:0] allowLvl;
  vqc_win_t    winRaw;
  vqc_win_t    winSync;
  logic        rdSvc;
  logic        wrSvc;
  logic        armNow;
  logic [15:0] armBit;
  logic [15:0] clrBit;
  logic [5:0]  lvlIdx;
  logic [4:0]  rteIdx;

  vqc_addr_mem #(.DEPTH(NUM_LINES)) u_mem (
    .clk   (clk),
    .rst_b (rst_b),
    .port  (memBus.mem)
  );

  // Scan keeps first hit on ties, so lower index beats equal level
  function automatic vqc_win_t pickWinner(
    input logic [31:0]      req,
    input logic             chReq,
    input logic [32:0][3:0] lvl,
    input logic [15:0]      allow
  );
    vqc_win_t w;
    logic     r;
    w = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      r = (i < NUM_LINES) ? req[i[4:0]] : chReq;
      if (r && allow[lvl[i]] && (!w.valid || lvl[i] < w.lvl)) begin
        w.valid = 1'b1;
        w.idx   = i[5:0];
        w.lvl   = lvl[i];
      end
    end
    return w;
  endfunction : pickWinner

  // Unregistered chain path trades metastability margin for latency
  assign chainIrq = chain_irq_register_sel ? st_ff.s2Ch[0]
                                           : ~chain_irq_in_n;
  assign chainFiq = chain_fiq_register_sel ? st_ff.s2Ch[1]
                                           : ~chain_fiq_in_n;

  assign raw_request_status = hwReq | st_ff.swReq;
  assign irq_routed_vector  = raw_request_status & st_ff.enable
                              & ~st_ff.select;
  assign fiq_routed_vector  = raw_request_status & st_ff.enable
                              & st_ff.select;
  assign irqVecSync = (st_ff.s2Req | st_ff.swReq) & st_ff.enable
                      & ~st_ff.select;

  // A level is allowed while its swMask bit is set and no equal or higher level is in service
  always_comb begin
    allowLvl = '0;
    for (int l = 0; l < NUM_LEVELS; l++) begin
      allowLvl[l] = st_ff.swMask[l] && !(|(st_ff.inService
                    & ((16'h0002 << l) - 16'h0001)));
    end
  end

  assign winRaw  = pickWinner(irq_routed_vector, chainIrq,
                              st_ff.level, allowLvl);
  assign winSync = pickWinner(irqVecSync, st_ff.s2Ch[0],
                              st_ff.level, allowLvl);

  always_comb begin
    slice_win_flag = '0;
    if (winRaw.valid && winRaw.idx != CHAIN_IDX) begin
      slice_win_flag[winRaw.idx[4:0]] = 1'b1;
    end
  end

  // Clock stopped still lets requests through to the pins
  assign irq_out_n = ~winRaw.valid;
  assign fiq_out_n = ~(|fiq_routed_vector | chainFiq);
  assign chain_ack_out = port_ack_in && winSync.valid
                         && winSync.idx == CHAIN_IDX;

  assign rdSvc  = rdStb && addr == SVC_OFS;
  assign wrSvc  = wrStb && addr == SVC_OFS;
  // Transient source: no winner at read, so nothing is armed
  assign armNow = (rdSvc || port_ack_in) && winSync.valid;
  assign armBit = armNow ? (16'h0001 << winSync.lvl) : 16'h0000;
  assign clrBit = st_ff.inService & (~st_ff.inService + 16'h0001);
  assign lvlIdx = addr[7:2];
  assign rteIdx = addr[6:2];

  // Upper half of the routine page is unmapped; keep it from aliasing
  assign memBus.wrEn   = wrStb && addr[11:8] == ROUTINE_PG && !addr[7];
  assign memBus.wrIdx  = rteIdx;
  assign memBus.wrData = wdata;
  assign memBus.rdIdxA = rteIdx;
  assign memBus.rdIdxB = winSync.idx[4:0];

  always_comb begin
    nxt_st       = st_ff;
    nxt_st.s1Req = hwReq;
    nxt_st.s2Req = st_ff.s1Req;
    nxt_st.s1Ch  = {~chain_fiq_in_n, ~chain_irq_in_n};
    nxt_st.s2Ch  = st_ff.s1Ch;
    nxt_st.rdMem = 1'b0;

    // Sticky, set beats clear
    nxt_st.sampled = st_ff.sampled | st_ff.s2Req;
    if (wrStb && addr == SAMPCLR_OFS) begin
      nxt_st.sampled = (st_ff.sampled & ~wdata) | st_ff.s2Req;
    end

    // Release one nesting level, then arm; arm wins a clash
    if (wrSvc) begin
      nxt_st.inService = st_ff.inService & ~clrBit;
    end
    nxt_st.inService = nxt_st.inService | armBit;

    // Address read from memory lands one cycle after index
    nxt_st.winValidQ = winSync.valid;
    nxt_st.winIdxQ   = winSync.idx;
    if (st_ff.winValidQ) begin
      nxt_st.serviceAddr = (st_ff.winIdxQ == CHAIN_IDX) ? chainAddrIn
                           : memBus.rdDataB;
    end

    if (wrStb) begin
      case (addr)
        ENSET_OFS:  nxt_st.enable = st_ff.enable | wdata;
        ENCLR_OFS:  nxt_st.enable = st_ff.enable & ~wdata;
        SELECT_OFS: nxt_st.select = wdata;
        SWSET_OFS:  nxt_st.swReq  = st_ff.swReq | wdata;
        SWCLR_OFS:  nxt_st.swReq  = st_ff.swReq & ~wdata;
        SWMASK_OFS: nxt_st.swMask = wdata[15:0];
        default: begin
          if (addr[11:8] == LEVEL_PG && lvlIdx <= CHAIN_IDX) begin
            nxt_st.level[lvlIdx] = wdata[3:0];
          end
        end
      endcase
    end

    if (rdStb) begin
      case (addr)
        RAW_OFS:    nxt_st.rdData = raw_request_status;
        IRQST_OFS:  nxt_st.rdData = irq_routed_vector;
        FIQST_OFS:  nxt_st.rdData = fiq_routed_vector;
        ENSET_OFS:  nxt_st.rdData = st_ff.enable;
        SELECT_OFS: nxt_st.rdData = st_ff.select;
        SWSET_OFS:  nxt_st.rdData = st_ff.swReq;
        SAMP_OFS:   nxt_st.rdData = st_ff.sampled;
        SWMASK_OFS: nxt_st.rdData = {16'h0000, st_ff.swMask};
        SVC_OFS:    nxt_st.rdData = st_ff.serviceAddr;
        default: begin
          nxt_st.rdData = 32'h0000_0000;
          if (addr[11:8] == ROUTINE_PG && addr[7] == 1'b0) begin
            nxt_st.rdMem = 1'b1;
          end else if (addr[11:8] == LEVEL_PG && lvlIdx <= CHAIN_IDX) begin
            nxt_st.rdData = {28'h000_0000, st_ff.level[lvlIdx]};
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff        <= '0;
      st_ff.swMask <= SWMASK_RST;
      st_ff.level  <= {NUM_SRC{LOWEST_LVL}};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata = st_ff.rdMem ? memBus.rdDataA : st_ff.rdData;
  assign slice_routine_addr = st_ff.serviceAddr;

  // Checks
  fiq_merge_a: assert property (@(posedge clk) disable iff (!rst_b)
    (|fiq_routed_vector || chainFiq) |-> !fiq_out_n)
    else $error("fiq output not asserted for pending fast request");

  status_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
    ((irq_routed_vector | fiq_routed_vector) & ~st_ff.enable) == 0
    && (irq_routed_vector & st_ff.select) == 0)
    else $error("disabled or fiq-steered line seen in irq status");

  read_arm_a: assert property (@(posedge clk) disable iff (!rst_b)
    rdSvc && winSync.valid |=> st_ff.inService[$past(winSync.lvl)])
    else $error("service address read did not arm priority mask");

  ack_arm_a: assert property (@(posedge clk) disable iff (!rst_b)
    port_ack_in && winSync.valid && !wrSvc
    |=> st_ff.inService != 16'h0000)
    else $error("acknowledge did not arm priority mask");

  transient_noarm_a: assert property (@(posedge clk) disable iff (!rst_b)
    rdSvc && !winSync.valid && st_ff.inService == 16'h0000
    |=> st_ff.inService == 16'h0000)
    else $error("mask armed with no active source");

  write_release_a: assert property (@(posedge clk) disable iff (!rst_b)
    wrSvc && !armNow && $onehot(st_ff.inService)
    |=> st_ff.inService == 16'h0000)
    else $error("service address write left mask armed");

  svc_read_data_a: assert property (@(posedge clk) disable iff (!rst_b)
    rdSvc |=> rdata == $past(st_ff.serviceAddr))
    else $error("service address read data wrong");

  idle_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    !st_ff.winValidQ |=> $stable(st_ff.serviceAddr))
    else $error("service address changed with no winner");

  sample_sticky_a: assert property (@(posedge clk) disable iff (!rst_b)
    st_ff.s2Req[0] ##1 !(wrStb && addr == SAMPCLR_OFS)
    |=> st_ff.sampled[0])
    else $error("sampled status lost a request");

  chain_ack_a: assert property (@(posedge clk) disable iff (!rst_b)
    chain_ack_out |-> port_ack_in && st_ff.s2Ch[0])
    else $error("chain acknowledge without acknowledge or request");

  both_cov: cover property (@(posedge clk) disable iff (!rst_b)
    !irq_out_n && !fiq_out_n);
  arm_cov: cover property (@(posedge clk) disable iff (!rst_b)
    rdSvc && winSync.valid ##[1:20] wrSvc);
  chain_cov: cover property (@(posedge clk) disable iff (!rst_b)
    winSync.valid && winSync.idx == CHAIN_IDX);
  nest_cov: cover property (@(posedge clk) disable iff (!rst_b)
    !$onehot0(st_ff.inService));
endmodule : vqc_core

// ---- vqc_chain_model.sv ----
module vqc_chain_model #(
  // Arbitrary routine address for the upstream controller
  parameter logic [31:0] ROUTINE = 32'hC0DE_0040
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        raiseIrq,
  input  wire logic        raiseFiq,
  input  wire logic        ackIn,
  output logic             irq_n,
  output logic             fiq_n,
  output logic [31:0]      addrOut
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pendIrq_ff;

  // Request stays up until the acknowledge reaches us
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pendIrq_ff <= 1'b0;
    end else if (raiseIrq) begin
      pendIrq_ff <= 1'b1;
    end else if (ackIn) begin
      pendIrq_ff <= 1'b0;
    end
  end

  assign irq_n   = ~pendIrq_ff;
  assign fiq_n   = ~raiseFiq;
  // Address is stale junk when not requesting
  assign addrOut = pendIrq_ff ? ROUTINE : ~ROUTINE;
endmodule : vqc_chain_model

// ---- vqc_core_tb.sv ----
module vqc_core_tb;
  import vqc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] CH_RTN = 32'hC0DE_0040;
  logic clk, rst_b, wrStb, rdStb, port_ack_in, chain_ack_out;
  logic chain_irq_in_n, chain_fiq_in_n, irq_out_n, fiq_out_n;
  logic chain_irq_register_sel, chain_fiq_register_sel;
  logic raiseIrq, raiseFiq;
  logic [ADDR_W-1:0] addr;
  logic [31:0] wdata, rdata, hwReq, chainAddrIn, d;
  logic [31:0] slice_win_flag, slice_routine_addr;
  int num_errors, total_checks;

  vqc_core vqc_core_i (.clk(clk), .rst_b(rst_b), .addr(addr),
    .wdata(wdata), .wrStb(wrStb), .rdStb(rdStb), .rdata(rdata),
    .hwReq(hwReq), .chain_irq_in_n(chain_irq_in_n),
    .chain_fiq_in_n(chain_fiq_in_n), .chainAddrIn(chainAddrIn),
    .chain_irq_register_sel(chain_irq_register_sel),
    .chain_fiq_register_sel(chain_fiq_register_sel),
    .port_ack_in(port_ack_in), .chain_ack_out(chain_ack_out),
    .irq_out_n(irq_out_n), .fiq_out_n(fiq_out_n),
    .slice_win_flag(slice_win_flag),
    .slice_routine_addr(slice_routine_addr));

  vqc_chain_model #(.ROUTINE(CH_RTN)) vqc_chain_model_i (.clk(clk),
    .rst_b(rst_b), .raiseIrq(raiseIrq), .raiseFiq(raiseFiq),
    .ackIn(chain_ack_out), .irq_n(chain_irq_in_n),
    .fiq_n(chain_fiq_in_n), .addrOut(chainAddrIn));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [31:0] rtn(input int i);
    return 32'hA000_0000 | 32'(i);
  endfunction : rtn

  task automatic results();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  task automatic check(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    wrStb <= 1'b1;
    addr  <= a;
    wdata <= v;
    @(posedge clk);
    wrStb <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    @(posedge clk);
    rdStb <= 1'b1;
    addr  <= a;
    @(posedge clk);
    rdStb <= 1'b0;
    #1;
    v = rdata;
  endtask : rd

  // Service address lags the pins by a few cycles
  task automatic waitAddr(input logic [31:0] exp);
    int n;
    n = 0;
    while (slice_routine_addr !== exp && n < 40) begin
      tick(1);
      n++;
    end
    check("service address", exp, slice_routine_addr);
    if (slice_routine_addr !== exp) results();
  endtask : waitAddr

  task automatic t_reset();
    check("irq out idle", 32'h1, 32'(irq_out_n));
    check("fiq out idle", 32'h1, 32'(fiq_out_n));
    rd(12'h21C, d);
    check("line level", 32'hF, d);
    rd(12'h280, d);
    check("chain level", 32'hF, d);
    rd(ENSET_OFS, d);
    check("enables", 32'h0, d);
    rd(SWSET_OFS, d);
    check("sw requests", 32'h0, d);
    rd(12'h0FC, d);
    check("unmapped read", 32'h0, d);
    for (int i = 0; i < 8; i++) wr(12'h100 + 12'(4 * i), rtn(i));
    rd(12'h114, d);
    check("routine readback", rtn(5), d);
  endtask : t_reset

  task automatic t_priority();
    @(posedge clk);
    hwReq <= 32'h0000_0028;
    tick(3);
    check("disabled irq", 32'h1, 32'(irq_out_n));
    rd(RAW_OFS, d);
    check("raw status", 32'h0000_0028, d);
    wr(ENSET_OFS, 32'h0000_0028);
    #1;
    check("enabled irq", 32'h0, 32'(irq_out_n));
    check("tie winner", 32'h0000_0008, slice_win_flag);
    waitAddr(rtn(3));
    wr(12'h214, 32'h0);
    tick(1);
    check("level winner", 32'h0000_0020, slice_win_flag);
    waitAddr(rtn(5));
  endtask : t_priority

  task automatic t_mask();
    rd(SVC_OFS, d);
    check("svc read", rtn(5), d);
    tick(1);
    check("armed irq", 32'h1, 32'(irq_out_n));
    rd(IRQST_OFS, d);
    check("irq status unmasked", 32'h0000_0028, d);
    rd(RAW_OFS, d);
    check("raw unmasked", 32'h0000_0028, d);
    wr(SVC_OFS, 32'h0);
    tick(1);
    check("released irq", 32'h0, 32'(irq_out_n));
    port_ack_in <= 1'b1;
    @(posedge clk);
    port_ack_in <= 1'b0;
    tick(1);
    check("ack armed irq", 32'h1, 32'(irq_out_n));
    wr(SVC_OFS, 32'h0);
    hwReq <= 32'h0;
    wr(ENCLR_OFS, 32'hFFFF_FFFF);
    tick(6);
    check("idle irq", 32'h1, 32'(irq_out_n));
    check("idle svc kept", rtn(5), slice_routine_addr);
  endtask : t_mask

  task automatic t_soft_fiq();
    wr(SWSET_OFS, 32'h0000_0002);
    wr(ENSET_OFS, 32'h0000_0082);
    wr(SELECT_OFS, 32'h0000_0080);
    #1;
    check("soft irq", 32'h0, 32'(irq_out_n));
    rd(RAW_OFS, d);
    check("soft raw", 32'h0000_0002, d);
    hwReq <= 32'h0000_0080;
    tick(1);
    check("fiq local", 32'h0, 32'(fiq_out_n));
    check("irq with fiq", 32'h0, 32'(irq_out_n));
    rd(FIQST_OFS, d);
    check("fiq status", 32'h0000_0080, d);
    hwReq <= 32'h0;
    tick(4);
    rd(SAMP_OFS, d);
    check("sampled sticky", 32'h0000_0080, d & 32'h80);
    wr(SAMPCLR_OFS, 32'h0000_0080);
    rd(SAMP_OFS, d);
    check("sampled cleared", 32'h0, d & 32'h80);
    wr(SWCLR_OFS, 32'h0000_0002);
    wr(ENCLR_OFS, 32'hFFFF_FFFF);
    wr(SELECT_OFS, 32'h0);
  endtask : t_soft_fiq

  task automatic t_chain();
    raiseIrq <= 1'b1;
    @(posedge clk);
    raiseIrq <= 1'b0;
    #1;
    check("chain irq direct", 32'h0, 32'(irq_out_n));
    waitAddr(CH_RTN);
    @(posedge clk);
    port_ack_in <= 1'b1;
    #1;
    check("chain ack", 32'h1, 32'(chain_ack_out));
    @(posedge clk);
    port_ack_in <= 1'b0;
    raiseFiq <= 1'b1;
    tick(1);
    check("chain fiq", 32'h0, 32'(fiq_out_n));
    wr(SVC_OFS, 32'h0);
  endtask : t_chain

  // Registered chain path shows the request two edges late
  task automatic t_chain_reg();
    raiseFiq <= 1'b0;
    tick(3);
    chain_irq_register_sel <= 1'b1;
    raiseIrq <= 1'b1;
    @(posedge clk);
    raiseIrq <= 1'b0;
    #1;
    check("chain irq reg early", 32'h1, 32'(irq_out_n));
    tick(2);
    check("chain irq reg", 32'h0, 32'(irq_out_n));
    port_ack_in <= 1'b1;
    #1;
    check("chain ack reg", 32'h1, 32'(chain_ack_out));
    @(posedge clk);
    port_ack_in <= 1'b0;
    wr(SVC_OFS, 32'h0);
  endtask : t_chain_reg

  initial begin
    rst_b = 1'b0;
    wrStb = 1'b0;
    rdStb = 1'b0;
    addr = '0;
    wdata = '0;
    hwReq = '0;
    port_ack_in = 1'b0;
    raiseIrq = 1'b0;
    raiseFiq = 1'b0;
    chain_irq_register_sel = 1'b0;
    chain_fiq_register_sel = 1'b0;
    num_errors = 0;
    total_checks = 0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    tick(1);
    t_reset();
    t_priority();
    t_mask();
    t_soft_fiq();
    t_chain();
    t_chain_reg();
    results();
  end
endmodule : vqc_core_tb
